/* timer_defs.svh */
// Register offsets, reset values and divider counts of the reload timer
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CTL_ADDR 8'h91
`define RLD_LO_ADDR 8'h92
`define RLD_HI_ADDR 8'h93
`define CNT_LO_ADDR 8'h94

// ------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------
`define CTL_HFLAG 7
`define CTL_LFLAG 6
`define CTL_UNUSED 1

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CTL_RESET 8'h00
`define RLD_RESET 8'h00
`define CNT_RESET 8'h00

// ------------------------------------------------------------
// Divider counts
// ------------------------------------------------------------
`define SYS_DIV 4'hc
`define SYS_DIV_LAST (`SYS_DIV - 4'h1)
`define EXT_DIV_LAST 3'h7

`endif

/* timer_pkg.sv */
// Types shared by the reload timer files
package timer_pkg;

   // ------------------------------------------------------------
   // Control register layout
   // ------------------------------------------------------------
   typedef struct packed {
      logic high_overflow_flag;
      logic low_overflow_flag;
      logic low_byte_irq_enable;
      logic comparator_capture_enable;
      logic split_mode_select;
      logic run_control;
      logic unused;
      logic ext_clock_select;
   } ctl_s;

   // ------------------------------------------------------------
   // Register port request
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sfr_req_s;

endpackage

/* clk_tick_gen.sv */
// Divide-by-12 and synchronised external divide-by-8 enables
`include "timer_defs.svh"
module clk_tick_gen import timer_pkg::*; (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ext_osc,
   output logic sys12_tick_q,
   output logic ext8_tick_q
);
   logic [3:0] div12_q;
   logic [2:0] div8_q;
   logic [2:0] sync_q;
   logic ext_rise;

   assign ext_rise = sync_q[1] & ~sync_q[2];

   // ------------------------------------------------------------
   // System clock divider
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         div12_q <= 4'h0;
         sys12_tick_q <= 1'b0;
      end else begin
         sys12_tick_q <= (div12_q == `SYS_DIV_LAST);
         div12_q <= (div12_q == `SYS_DIV_LAST) ? 4'h0 : div12_q + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // External oscillator sync and divider
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sync_q <= 3'h0;
         div8_q <= 3'h0;
         ext8_tick_q <= 1'b0;
      end else begin
         sync_q <= {sync_q[1:0], ext_osc};
         ext8_tick_q <= ext_rise && (div8_q == `EXT_DIV_LAST);
         if (ext_rise) begin
            div8_q <= div8_q + 3'h1;
         end
      end
   end
endmodule

/* byte_counter.sv */
// One 8-bit up counter with wrap detect, reload and direct write
`include "timer_defs.svh"
module byte_counter import timer_pkg::*; (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic inc,
   input wire logic reload_en,
   input wire logic [7:0] reload_val,
   input wire logic wr,
   input wire logic [7:0] wdata,
   output logic [7:0] count_q,
   output logic wrap
);
   assign wrap = inc && (count_q == 8'hff);

   // ------------------------------------------------------------
   // Count, wrap and reload
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         count_q <= `CNT_RESET;
      end else if (wr) begin
         count_q <= wdata;
      end else if (wrap) begin
         count_q <= reload_en ? reload_val : 8'h00;
      end else if (inc) begin
         count_q <= count_q + 8'h01;
      end
   end
endmodule

/* auto_reload_timer.sv */
// Auto-reload timer: control, reload and low count registers
`include "timer_defs.svh"
// Summary of operation
// - High byte wrap (16-bit: 0xFFFF to the 16-bit reload value) sets high flag.
// - High flag raises interrupt when the timer interrupt is enabled.
// - Flags only clear by software writing zero; hardware never clears.
// - Low byte wrap sets low flag in both modes.
// - Low-byte enable plus interrupt enable makes low wraps interrupt too.
// - Capture enable copies count into reload bytes on comparator rise.
// - Each capture event produces an interrupt when enabled.
// - Split select zero gives one 16-bit counter, one gives two 8-bit.
// - Run gates counting; split mode gates only the high counter.
// - Control bit 1 reads zero and ignores writes.
// - External select picks system clock/12 or synced external/8.
// - In split mode the external select serves both bytes.
// - Reload bytes are read/write storage, also loaded by a capture event.
// - Low count register reads and writes the low counter byte.
// - 16-bit wrap loads the 16-bit reload value.
// - In split mode each byte reloads from its own reload byte.
// - Per-byte fast select picks system clock, else external choice.
module auto_reload_timer import timer_pkg::*; (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire sfr_req_s sfr_req,
   output logic [7:0] sfr_rdata_q,
   input wire logic timer_irq_enable,
   input wire logic high_byte_fast_clock_select,
   input wire logic low_byte_fast_clock_select,
   input wire logic comparator_zero_output,
   input wire logic ext_osc,
   input wire logic high_byte_wr,
   input wire logic [7:0] high_byte_wdata,
   output logic [7:0] count_high_byte,
   output logic timer_irq_q
);
   ctl_s ctl_q;
   ctl_s ctl_wr_val;
   logic [7:0] reload_low_q;
   logic [7:0] reload_high_q;
   logic [7:0] cnt [2];
   logic [1:0] inc;
   logic [1:0] wrap;
   logic [1:0] rld_en;
   logic [1:0] cnt_wr;
   logic [7:0] rld_val [2];
   logic [7:0] cnt_wdata [2];
   logic [2:0] cmp_sync_q;
   logic cap_evt;
   logic t12;
   logic t8;
   logic t_lo;
   logic t_hi;
   logic ctl_wr;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   function automatic logic hit(sfr_req_s r, logic [7:0] a);
      return r.wr && (r.addr == a);
   endfunction

   function automatic logic src_tick(logic fast, logic xclk,
                                     logic s12, logic e8);
      return fast ? 1'b1 : (xclk ? e8 : s12);
   endfunction

   // ------------------------------------------------------------
   // Clock sources
   // ------------------------------------------------------------
   clk_tick_gen u_ticks (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .ext_osc(ext_osc),
      .sys12_tick_q(t12),
      .ext8_tick_q(t8)
   );

   assign t_lo = src_tick(low_byte_fast_clock_select,
                          ctl_q.ext_clock_select, t12, t8);
   assign t_hi = src_tick(high_byte_fast_clock_select,
                          ctl_q.ext_clock_select, t12, t8);

   // ------------------------------------------------------------
   // Counter chaining
   // ------------------------------------------------------------
   // mode and run gating
   assign inc[0] = ctl_q.split_mode_select ? t_lo
                                           : (t_lo & ctl_q.run_control);
   assign inc[1] = ctl_q.split_mode_select ? (t_hi & ctl_q.run_control)
                   : (t_lo & ctl_q.run_control & wrap[0]);
   assign rld_en[0] = ctl_q.split_mode_select | wrap[1];
   assign rld_en[1] = 1'b1;
   assign rld_val[0] = reload_low_q;
   assign rld_val[1] = reload_high_q;
   assign ctl_wr = hit(sfr_req, `CTL_ADDR);
   assign cnt_wr[0] = hit(sfr_req, `CNT_LO_ADDR);
   assign cnt_wr[1] = high_byte_wr;
   assign cnt_wdata[0] = sfr_req.wdata;
   assign cnt_wdata[1] = high_byte_wdata;

   generate
      for (genvar i = 0; i < 2; i++) begin : g_byte
         byte_counter u_cnt (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .inc(inc[i]),
            .reload_en(rld_en[i]),
            .reload_val(rld_val[i]),
            .wr(cnt_wr[i]),
            .wdata(cnt_wdata[i]),
            .count_q(cnt[i]),
            .wrap(wrap[i])
         );
      end
   endgenerate

   assign count_high_byte = cnt[1];

   // ------------------------------------------------------------
   // Comparator edge capture
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cmp_sync_q <= 3'h0;
      end else begin
         cmp_sync_q <= {cmp_sync_q[1:0], comparator_zero_output};
      end
   end

   assign cap_evt = ctl_q.comparator_capture_enable
                    & cmp_sync_q[1] & ~cmp_sync_q[2];

   // ------------------------------------------------------------
   // Reload registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         reload_low_q <= `RLD_RESET;
         reload_high_q <= `RLD_RESET;
      end else if (cap_evt) begin
         reload_low_q <= cnt[0];
         reload_high_q <= cnt[1];
      end else begin
         if (hit(sfr_req, `RLD_LO_ADDR)) begin
            reload_low_q <= sfr_req.wdata;
         end
         if (hit(sfr_req, `RLD_HI_ADDR)) begin
            reload_high_q <= sfr_req.wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   assign ctl_wr_val = ctl_s'(sfr_req.wdata);

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ctl_q <= ctl_s'(`CTL_RESET);
      end else begin
         if (ctl_wr) begin
            ctl_q.low_byte_irq_enable <= ctl_wr_val.low_byte_irq_enable;
            ctl_q.comparator_capture_enable <=
               ctl_wr_val.comparator_capture_enable;
            ctl_q.split_mode_select <= ctl_wr_val.split_mode_select;
            ctl_q.run_control <= ctl_wr_val.run_control;
            ctl_q.ext_clock_select <= ctl_wr_val.ext_clock_select;
         end
         ctl_q.unused <= 1'b0;
         ctl_q.high_overflow_flag <= wrap[1] | cap_evt |
            (ctl_wr ? ctl_wr_val.high_overflow_flag
                    : ctl_q.high_overflow_flag);
         ctl_q.low_overflow_flag <= wrap[0] |
            (ctl_wr ? ctl_wr_val.low_overflow_flag
                    : ctl_q.low_overflow_flag);
      end
   end

   // ------------------------------------------------------------
   // Interrupt request
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         timer_irq_q <= 1'b0;
      end else begin
         timer_irq_q <= timer_irq_enable & (ctl_q.high_overflow_flag |
            (ctl_q.low_byte_irq_enable & ctl_q.low_overflow_flag));
      end
   end

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sfr_rdata_q <= 8'h00;
      end else if (sfr_req.rd) begin
         unique case (sfr_req.addr)
            `CTL_ADDR: sfr_rdata_q <= ctl_q;
            `RLD_LO_ADDR: sfr_rdata_q <= reload_low_q;
            `RLD_HI_ADDR: sfr_rdata_q <= reload_high_q;
            `CNT_LO_ADDR: sfr_rdata_q <= cnt[0];
            default: sfr_rdata_q <= 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   high_flag_set_a: assert property (
      wrap[1] |=> ctl_q.high_overflow_flag)
      else $error("high wrap did not set high flag");

   low_flag_set_a: assert property (
      wrap[0] |=> ctl_q.low_overflow_flag)
      else $error("low wrap did not set low flag");

   flag_hold_a: assert property (
      ctl_q.high_overflow_flag && !ctl_wr |=> ctl_q.high_overflow_flag)
      else $error("high flag cleared without a write");

   irq_high_a: assert property (
      timer_irq_enable && ctl_q.high_overflow_flag |=> timer_irq_q)
      else $error("no interrupt for high flag");

   irq_low_gate_a: assert property (
      !ctl_q.high_overflow_flag && !ctl_q.low_byte_irq_enable
      |=> !timer_irq_q)
      else $error("interrupt without enabled source");

   capture_copy_a: assert property (
      cap_evt |=> {reload_high_q, reload_low_q}
                  == $past({cnt[1], cnt[0]}) && ctl_q.high_overflow_flag)
      else $error("capture did not copy the count");

   reload_full_a: assert property (
      !ctl_q.split_mode_select && wrap[1] && !cnt_wr[0] && !cnt_wr[1]
      |=> {cnt[1], cnt[0]} == $past({reload_high_q, reload_low_q}))
      else $error("16-bit wrap did not reload");

   split_hold_a: assert property (
      ctl_q.split_mode_select && !ctl_q.run_control && !high_byte_wr
      |=> $stable(cnt[1]))
      else $error("high byte moved while stopped");

   unused_bit_a: assert property (
      sfr_req.rd && sfr_req.addr == `CTL_ADDR
      |=> !sfr_rdata_q[`CTL_UNUSED])
      else $error("unused control bit read as one");

   low_flag_hold_a: assert property (
      ctl_q.low_overflow_flag && !ctl_wr |=> ctl_q.low_overflow_flag)
      else $error("low flag cleared without a write");

   flag_clear_a: assert property (
      ctl_wr && !ctl_wr_val.high_overflow_flag && !wrap[1] && !cap_evt
      |=> !ctl_q.high_overflow_flag)
      else $error("high flag not cleared by a zero write");

   irq_low_a: assert property (
      timer_irq_enable && ctl_q.low_byte_irq_enable
      && ctl_q.low_overflow_flag |=> timer_irq_q)
      else $error("no interrupt for enabled low flag");

   irq_off_a: assert property (
      !timer_irq_enable |=> !timer_irq_q)
      else $error("interrupt while timer interrupt disabled");

   split_reload_a: assert property (
      ctl_q.split_mode_select && wrap[0] && !cnt_wr[0]
      |=> cnt[0] == $past(reload_low_q))
      else $error("split low wrap did not reload");

   low_wrap_zero_a: assert property (
      !ctl_q.split_mode_select && wrap[0] && !wrap[1] && !cnt_wr[0]
      |=> cnt[0] == 8'h00)
      else $error("16-bit low wrap did not return to zero");

   count_write_a: assert property (
      cnt_wr[0] |=> cnt[0] == $past(sfr_req.wdata))
      else $error("low count write lost");

   run_stop_a: assert property (
      !ctl_q.split_mode_select && !ctl_q.run_control && !cnt_wr[0]
      |=> $stable(cnt[0]))
      else $error("low byte moved while stopped");

   fast_tick_a: assert property (
      low_byte_fast_clock_select
      && (ctl_q.run_control || ctl_q.split_mode_select) |-> inc[0])
      else $error("fast select did not count every cycle");

   capture_c: cover property (cap_evt ##2 timer_irq_q);
   wrap16_c: cover property (!ctl_q.split_mode_select && wrap[1]);
   split_low_c: cover property (ctl_q.split_mode_select && wrap[0]);
   ext_tick_c: cover property (ctl_q.ext_clock_select && t8 && inc[0]);
   low_irq_c: cover property (ctl_q.low_byte_irq_enable && timer_irq_q);
endmodule

/* test_auto_reload_timer.sv */
// Self-checking bench of the auto-reload timer
`include "timer_defs.svh"
module test_auto_reload_timer_three_regs import timer_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;

   logic ref_clk, nrst, irq_en, fhi, flo, cmp, ext, hwr, irq;
   sfr_req_s req;
   logic [7:0] rdata, chb, hwd, v, rl, rh, e;
   logic [1:0] ext_cnt;
   int num_errors, compares, n;

`define CHK(a, b) begin \
   compares++; \
   if ((a) !== (b)) begin \
      num_errors++; \
      $display("mismatch at %0t: got %h want %h", $time, a, b); \
   end \
end

   auto_reload_timer DUT (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .sfr_req(req),
      .sfr_rdata_q(rdata),
      .timer_irq_enable(irq_en),
      .high_byte_fast_clock_select(fhi),
      .low_byte_fast_clock_select(flo),
      .comparator_zero_output(cmp),
      .ext_osc(ext),
      .high_byte_wr(hwr),
      .high_byte_wdata(hwd),
      .count_high_byte(chb),
      .timer_irq_q(irq)
   );

   // ------------------------------------------------------------
   // Clock and external oscillator
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (!nrst) begin
         ext_cnt <= 2'h0;
         ext <= 1'b0;
      end else begin
         ext_cnt <= ext_cnt + 2'h1;
         ext <= ext_cnt[1];
      end
   end

   // ------------------------------------------------------------
   // Bus tasks and expectations
   // ------------------------------------------------------------
   task automatic end_of_test();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] x);
      rd(a, v);
      `CHK(v, x)
   endtask

   task automatic hw(input logic [7:0] d);
      @(posedge ref_clk);
      hwr <= 1'b1;
      hwd <= d;
      @(posedge ref_clk);
      hwr <= 1'b0;
   endtask

   task automatic poll(input int b);
      n = 0;
      v = 8'h00;
      while (v[b] !== 1'b1) begin
         rd(`CTL_ADDR, v);
         n++;
         if (n > 200) begin
            num_errors++;
            $display("mismatch at %0t: wait ran out", $time);
            end_of_test();
         end
      end
   endtask

   // Counts expected for source s over c cycles of run time
   function automatic logic [7:0] exp_cnt(input int s, input int c);
      if (s == 2) begin
         return 8'(c + 2);
      end
      return 8'((c + 2) / ((s == 1) ? 32 : 12));
   endfunction

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      req = '0;
      irq_en = 1'b0;
      fhi = 1'b0;
      flo = 1'b0;
      cmp = 1'b0;
      hwr = 1'b0;
      hwd = 8'h00;
      num_errors = 0;
      compares = 0;
      void'($urandom(32'hd6d3));
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      cyc(1);
      `CHK(irq, 1'b0)
      `CHK(chb, 8'h00)
      for (logic [7:0] a = 8'h90; a < 8'h95; a++) begin
         rchk(a, 8'h00);
      end
      wr(8'h90, 8'hff);
      rchk(8'h90, 8'h00);
      wr(`CTL_ADDR, 8'h02);
      rchk(`CTL_ADDR, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rl = 8'($urandom);
         rh = 8'($urandom);
         e = 8'($urandom);
         wr(`RLD_LO_ADDR, rl);
         wr(`RLD_HI_ADDR, rh);
         wr(`CNT_LO_ADDR, e);
         rchk(`RLD_LO_ADDR, rl);
         rchk(`RLD_HI_ADDR, rh);
         rchk(`CNT_LO_ADDR, e);
         e = 8'($urandom) & 8'h2b;
         wr(`CNT_LO_ADDR, 8'h00);
         wr(`CTL_ADDR, e);
         rchk(`CTL_ADDR, e & 8'h29);
         wr(`CTL_ADDR, 8'h00);
      end
      // Flags and interrupt gating
      irq_en <= 1'b1;
      wr(`CTL_ADDR, 8'hc0);
      cyc(2);
      rchk(`CTL_ADDR, 8'hc0);
      `CHK(irq, 1'b1)
      irq_en <= 1'b0;
      cyc(2);
      `CHK(irq, 1'b0)
      irq_en <= 1'b1;
      wr(`CTL_ADDR, 8'h40);
      cyc(2);
      `CHK(irq, 1'b0)
      wr(`CTL_ADDR, 8'h60);
      cyc(2);
      `CHK(irq, 1'b1)
      wr(`CTL_ADDR, 8'h00);
      cyc(2);
      `CHK(irq, 1'b0)
      // Full 16-bit wrap and reload
      rl = 8'($urandom) & 8'h7f;
      rh = 8'($urandom) & 8'h7f;
      wr(`RLD_LO_ADDR, rl);
      wr(`RLD_HI_ADDR, rh);
      wr(`CNT_LO_ADDR, 8'hfe);
      hw(8'hff);
      flo <= 1'b1;
      wr(`CTL_ADDR, 8'h04);
      poll(7);
      `CHK(v[7], 1'b1)
      `CHK(v[6], 1'b1)
      `CHK(irq, 1'b1)
      wr(`CTL_ADDR, 8'h00);
      cyc(1);
      `CHK(chb, rh)
      rd(`CNT_LO_ADDR, v);
      `CHK(v >= rl && v < rl + 8'h20, 1'b1)
      // Split mode: low runs alone, then high with run
      hw(8'h55);
      wr(`CNT_LO_ADDR, 8'hfd);
      wr(`CTL_ADDR, 8'h08);
      poll(6);
      `CHK(v[7], 1'b0)
      `CHK(chb, 8'h55)
      rd(`CNT_LO_ADDR, v);
      `CHK(v >= rl && v < rl + 8'h20, 1'b1)
      hw(8'hfe);
      fhi <= 1'b1;
      wr(`CTL_ADDR, 8'h0c);
      poll(7);
      `CHK(chb >= rh && chb < rh + 8'h20, 1'b1)
      wr(`CTL_ADDR, 8'h00);
      fhi <= 1'b0;
      // Clock sources: sys/12, ext/8, fast override
      for (int s = 0; s < 3; s++) begin
         flo <= (s == 2);
         wr(`CNT_LO_ADDR, 8'h00);
         wr(`CTL_ADDR, (s == 0) ? 8'h04 : 8'h05);
         cyc((s == 1) ? 320 : 240);
         wr(`CTL_ADDR, 8'h00);
         rd(`CNT_LO_ADDR, v);
         e = exp_cnt(s, (s == 1) ? 320 : 240);
         `CHK(v + 8'h2 >= e && v <= e + 8'h2, 1'b1)
      end
      // Comparator capture, first disabled then enabled
      flo <= 1'b1;
      wr(`RLD_LO_ADDR, 8'h00);
      wr(`RLD_HI_ADDR, 8'h00);
      wr(`CNT_LO_ADDR, 8'h00);
      hw(8'h12);
      wr(`CTL_ADDR, 8'h04);
      cmp <= 1'b1;
      cyc(6);
      cmp <= 1'b0;
      cyc(2);
      rchk(`RLD_HI_ADDR, 8'h00);
      wr(`CTL_ADDR, 8'h14);
      cmp <= 1'b1;
      cyc(6);
      rd(`CTL_ADDR, v);
      `CHK(v[7], 1'b1)
      `CHK(irq, 1'b1)
      rchk(`RLD_HI_ADDR, 8'h12);
      rd(`RLD_LO_ADDR, v);
      `CHK(v < 8'h40, 1'b1)
      cmp <= 1'b0;
      wr(`CTL_ADDR, 8'h00);
      end_of_test();
   end
endmodule
